// file: logic/two_wire_pkg.sv
// Purpose: Constants for the two-wire master transmitter
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   Status codes keep the prescaler bits at zero
package two_wire_pkg;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_DATA    = 4'h8;
  localparam logic [3:0] OFS_IRQ_ST  = 4'hC;
  localparam logic [4:0] OFS_IRQ_MSK = 5'h10;
  // Control bit positions
  localparam int B_FLAG  = 7;
  localparam int B_ACKEN = 6;
  localparam int B_START = 5;
  localparam int B_STOP  = 4;
  localparam int B_WCOL  = 3;
  localparam int B_EN    = 2;
  localparam int B_IE    = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'hF8;
  localparam logic [7:0] DATA_RESET    = 8'hFF;
  // Status codes
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RSTART   = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK = 8'h18;
  localparam logic [7:0] ST_ADDR_NAK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_DATA_NAK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_RX_ADDR_ACK = 8'h40;
  localparam logic [7:0] ST_RX_ADDR_NAK = 8'h48;
  localparam logic [7:0] ST_IDLE     = 8'hF8;
  localparam logic [7:0] STATUS_MASK = 8'hF8;
  // Bit timing: system clocks per half bit (one low or one high phase)
  localparam int QUARTER_CYCLES = 4;
  localparam int SAMPLE_CYCLES  = 4;
endpackage

// file: logic/two_wire_unit.sv
// Purpose: Two-wire master transmitter with Avalon-MM registers
// Assumes: 20 MHz clk; sda and scl are open-drain, sampled through two flops
// Notes:   Master receive and slave modes end at their switch points
// Overview of operation
// - Four modes exist; software picks them; mode shows in a status field.
// - While the transfer flag is set, the bus transfer stays suspended.
// - Flag-clear, start one, stop zero, enable one: START once bus free.
// - After START the flag is set and status reads 0x08.
// - Address with write enters transmitter mode; with read, receiver mode.
// - After address with write: 0x18 ack, 0x20 nack, 0x38 arbitration lost.
// - Data write while flag low is dropped and sets write collision.
// - After a data byte: 0x28 on ack, 0x30 on nack.
// - In 0x18-0x30, a new byte with flag clear is sent and its ack bit read.
// - Stop one, start zero: send STOP, then clear the stop bit.
// - Start and stop both one: STOP then START, stop bit cleared.
// - Start one, stop zero after address or data: repeated START, 0x10.
// - In 0x10, address with write stays transmitter; with read goes receiver.
// - In 0x38, start zero releases bus; start one waits for free bus.
// - Read bit drives high, write low; low after byte means ack.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
module two_wire_unit
  import two_wire_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Two-wire pins
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // Interrupt
  output logic             irq
);

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_FREE, S_START_A, S_START_B, S_BIT_LOW, S_BIT_HIGH,
    S_ACK_LOW, S_ACK_HIGH, S_STOP_A, S_STOP_B, S_STOP_C, S_HOLD
  } phase_e;

  logic [1:0] sda_sync_reg, scl_sync_reg;
  logic       sda_s, scl_s, scl_prev_reg, bus_busy_reg;
  logic       sda_prev_reg;
  logic [7:0] control_reg, status_reg, data_reg, shift_reg;
  logic [1:0] irq_status_reg, irq_mask_reg;
  logic [1:0] mode_reg;
  phase_e     phase_reg;
  logic [7:0] tick_reg;
  logic [2:0] bit_reg;
  logic       addr_phase_reg, restart_after_stop_reg, owner_reg;
  logic       set_flag;
  logic [7:0] set_code;
  logic       tick_done;

  function automatic logic sel(input logic [4:0] a, input logic [4:0] ofs);
    sel = (a == ofs);
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'b11;
      scl_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
    end
  end
  assign sda_s = sda_sync_reg[1];
  assign scl_s = scl_sync_reg[1];

  // Bus busy detection from START/STOP seen on the wires
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      bus_busy_reg <= 1'b0;
    end else begin
      sda_prev_reg <= sda_s;
      scl_prev_reg <= scl_s;
      if (scl_s && scl_prev_reg && sda_prev_reg && !sda_s) bus_busy_reg <= 1'b1;
      else if (scl_s && scl_prev_reg && !sda_prev_reg && sda_s) bus_busy_reg <= 1'b0;
    end
  end

  // Bus access decode
  logic wr_ctrl, wr_data, wr_ist, wr_imsk, flag_clear;
  logic rd_ready_reg;
  // One wait state on reads so registered data stands at the accepting edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_ready_reg <= 1'b0;
    else rd_ready_reg <= read && !rd_ready_reg;
  end
  assign waitrequest = read && !rd_ready_reg;
  assign wr_ctrl = write && byteenable[0] && sel(address, {1'b0, OFS_CONTROL});
  assign wr_data = write && byteenable[0] && sel(address, {1'b0, OFS_DATA});
  assign wr_ist  = write && byteenable[0] && sel(address, {1'b0, OFS_IRQ_ST});
  assign wr_imsk = write && byteenable[0] && sel(address, OFS_IRQ_MSK);
  assign flag_clear = wr_ctrl && writedata[B_FLAG];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !rd_ready_reg) begin
      case (address)
        {1'b0, OFS_CONTROL}: readdata <= {24'h00_0000, control_reg};
        {1'b0, OFS_STATUS}:  readdata <= {22'h00_0000, mode_reg, status_reg & STATUS_MASK};
        {1'b0, OFS_DATA}:    readdata <= {24'h00_0000, data_reg};
        {1'b0, OFS_IRQ_ST}:  readdata <= {30'h0000_0000, irq_status_reg};
        OFS_IRQ_MSK:         readdata <= {30'h0000_0000, irq_mask_reg};
        default:             readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register: flag set wins over a clear in the same cycle
  logic stop_done;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        control_reg[B_ACKEN] <= writedata[B_ACKEN];
        control_reg[B_START] <= writedata[B_START];
        control_reg[B_STOP]  <= writedata[B_STOP];
        control_reg[B_EN]    <= writedata[B_EN];
        control_reg[B_IE]    <= writedata[B_IE];
        if (writedata[B_WCOL]) control_reg[B_WCOL] <= 1'b0;
      end
      if (stop_done) control_reg[B_STOP] <= 1'b0;
      if (flag_clear) control_reg[B_FLAG] <= 1'b0;
      if (set_flag) control_reg[B_FLAG] <= 1'b1;
      if (wr_data && !control_reg[B_FLAG]) control_reg[B_WCOL] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) data_reg <= DATA_RESET;
    else if (wr_data && control_reg[B_FLAG]) data_reg <= writedata[7:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) status_reg <= STATUS_RESET;
    else if (set_flag) status_reg <= set_code;
    else if (phase_reg == S_IDLE && !owner_reg && flag_clear) status_reg <= ST_IDLE;
  end

  // Interrupt status: bit0 flag set, bit1 write collision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 2'b00;
      irq_mask_reg   <= 2'b00;
    end else begin
      if (wr_imsk) irq_mask_reg <= writedata[1:0];
      irq_status_reg <= (irq_status_reg & ~(wr_ist ? writedata[1:0] : 2'b00))
                        | {wr_data && !control_reg[B_FLAG], set_flag};
    end
  end
  assign irq = (control_reg[B_FLAG] && control_reg[B_IE])
             || |(irq_status_reg & irq_mask_reg);

  // Bit engine
  assign tick_done = (tick_reg == 8'(QUARTER - 1));
  // Go condition: flag cleared with enable kept high
  logic go;
  assign go = flag_clear && writedata[B_EN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= S_IDLE;
      tick_reg <= 8'h00;
      bit_reg <= 3'd0;
      shift_reg <= 8'h00;
      addr_phase_reg <= 1'b0;
      restart_after_stop_reg <= 1'b0;
      owner_reg <= 1'b0;
      mode_reg <= 2'd0;
      sda_out <= 1'b1;
      scl_out <= 1'b1;
    end else begin
      tick_reg <= tick_done ? 8'h00 : tick_reg + 8'h01;
      case (phase_reg)
        S_IDLE, S_HOLD: begin
          tick_reg <= 8'h00;
          if (go) begin
            if (writedata[B_STOP] && owner_reg) begin
              phase_reg <= S_STOP_A;
              restart_after_stop_reg <= writedata[B_START];
              sda_out <= 1'b0;
            end else if (writedata[B_START] && owner_reg) begin
              phase_reg <= S_START_A;
              sda_out <= 1'b1;
            end else if (writedata[B_START]) begin
              phase_reg <= S_WAIT_FREE;
              sda_out <= 1'b1;
              scl_out <= 1'b1;
            end else if (owner_reg && status_reg != ST_ARB_LOST) begin
              shift_reg <= data_reg;
              addr_phase_reg <= (status_reg == ST_START) || (status_reg == ST_RSTART);
              bit_reg <= 3'd7;
              phase_reg <= S_BIT_LOW;
            end else begin
              owner_reg <= 1'b0;
              mode_reg <= 2'd3;
              sda_out <= 1'b1;
              scl_out <= 1'b1;
            end
          end
        end
        S_WAIT_FREE: if (!bus_busy_reg && tick_done) begin
          sda_out <= 1'b0;
          phase_reg <= S_START_B;
        end
        S_START_A: if (tick_done) begin
          scl_out <= 1'b1;
          if (scl_s) begin
            sda_out <= 1'b0;
            phase_reg <= S_START_B;
          end
        end
        S_START_B: if (tick_done) begin
          scl_out <= 1'b0;
          owner_reg <= 1'b1;
          phase_reg <= S_HOLD;
        end
        S_BIT_LOW: if (tick_done) begin
          sda_out <= shift_reg[bit_reg];
          scl_out <= 1'b1;
          phase_reg <= S_BIT_HIGH;
        end
        S_BIT_HIGH: if (tick_done && scl_s) begin
          if (sda_out && !sda_s) begin
            // Loser lets go of both lines, clock left high
            owner_reg <= 1'b0;
            sda_out <= 1'b1;
            phase_reg <= S_HOLD;
          end else if (bit_reg == 3'd0) begin
            scl_out <= 1'b0;
            phase_reg <= S_ACK_LOW;
          end else begin
            scl_out <= 1'b0;
            bit_reg <= bit_reg - 3'd1;
            phase_reg <= S_BIT_LOW;
          end
        end
        S_ACK_LOW: if (tick_done) begin
          sda_out <= 1'b1;
          scl_out <= 1'b1;
          phase_reg <= S_ACK_HIGH;
        end
        S_ACK_HIGH: if (tick_done && scl_s) begin
          scl_out <= 1'b0;
          phase_reg <= S_HOLD;
          if (addr_phase_reg) mode_reg <= shift_reg[0] ? 2'd1 : 2'd0;
        end
        S_STOP_A: if (tick_done) begin
          scl_out <= 1'b1;
          phase_reg <= S_STOP_B;
        end
        S_STOP_B: if (tick_done && scl_s) begin
          sda_out <= 1'b1;
          phase_reg <= S_STOP_C;
        end
        S_STOP_C: if (tick_done) begin
          owner_reg <= 1'b0;
          phase_reg <= restart_after_stop_reg ? S_WAIT_FREE : S_IDLE;
        end
        default: phase_reg <= S_IDLE;
      endcase
    end
  end
  assign stop_done = (phase_reg == S_STOP_C) && tick_done;

  // Flag set events and their codes
  always_comb begin
    set_flag = 1'b0;
    set_code = ST_IDLE;
    if (phase_reg == S_START_B && tick_done) begin
      set_flag = 1'b1;
      set_code = owner_reg ? ST_RSTART : ST_START;
    end else if (phase_reg == S_BIT_HIGH && tick_done && scl_s && sda_out && !sda_s) begin
      set_flag = 1'b1;
      set_code = ST_ARB_LOST;
    end else if (phase_reg == S_ACK_HIGH && tick_done && scl_s) begin
      set_flag = 1'b1;
      if (addr_phase_reg && shift_reg[0]) set_code = sda_s ? ST_RX_ADDR_NAK : ST_RX_ADDR_ACK;
      else if (addr_phase_reg) set_code = sda_s ? ST_ADDR_NAK : ST_ADDR_ACK;
      else set_code = sda_s ? ST_DATA_NAK : ST_DATA_ACK;
    end
  end

  assign sda_oe = !sda_out;
  assign scl_oe = !scl_out;

  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (control_reg[B_FLAG] && !flag_clear) |=> control_reg[B_FLAG])
    else $error("flag dropped without a clear");
  a_start_code: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_reg == S_START_B && tick_done && !owner_reg) |=> status_reg == ST_START)
    else $error("start code wrong");
  a_collision: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_data && !control_reg[B_FLAG]) |=> control_reg[B_WCOL] && data_reg == $past(data_reg))
    else $error("collision not handled");
  a_data_code: assert property (@(posedge clk) disable iff (!rst_n)
    (set_flag && phase_reg == S_ACK_HIGH && !addr_phase_reg) |=>
      (status_reg == ST_DATA_ACK || status_reg == ST_DATA_NAK))
    else $error("data code wrong");
  a_suspended: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_reg == S_HOLD && control_reg[B_FLAG] && !go) |=> phase_reg == S_HOLD)
    else $error("engine ran while flag set");
  a_stop_clears: assert property (@(posedge clk) disable iff (!rst_n)
    stop_done |=> !control_reg[B_STOP])
    else $error("stop bit not cleared");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (control_reg[B_FLAG] && control_reg[B_IE]) |-> irq)
    else $error("interrupt missing");
  a_rstart_code: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_reg == S_START_B && tick_done && owner_reg) |=> status_reg == ST_RSTART)
    else $error("repeated start code wrong");
  a_arb_release: assert property (@(posedge clk) disable iff (!rst_n)
    (set_flag && set_code == ST_ARB_LOST) |=> (sda_out && scl_out && !owner_reg))
    else $error("bus kept after lost arbitration");
  a_addr_code: assert property (@(posedge clk) disable iff (!rst_n)
    (set_flag && phase_reg == S_ACK_HIGH && addr_phase_reg && !shift_reg[0]) |=>
      (status_reg == ST_ADDR_ACK || status_reg == ST_ADDR_NAK))
    else $error("address code wrong");
  a_mode_rx: assert property (@(posedge clk) disable iff (!rst_n)
    (set_flag && (set_code == ST_RX_ADDR_ACK || set_code == ST_RX_ADDR_NAK)) |=> mode_reg == 2'd1)
    else $error("receiver mode not entered");
  c_start: cover property (@(posedge clk) set_flag && set_code == ST_START);
  c_addr_ack: cover property (@(posedge clk) set_flag && set_code == ST_ADDR_ACK);
  c_stop: cover property (@(posedge clk) stop_done);
  c_arb_lost: cover property (@(posedge clk) set_flag && set_code == ST_ARB_LOST);
endmodule

// file: tb/test_two_wire_unit.sv
// Purpose: Self-checking bench for the two-wire master transmitter
// Assumes: waitrequest answered by the design; status compared masked
// Notes:   QUARTER kept at 4 so a byte takes about 72 clocks
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_two_wire_unit;
  import two_wire_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, read, write, ack_en, grab;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        waitrequest, sda_out, sda_oe, scl_out, scl_oe, irq, pull;
  logic [7:0]  last_byte;
  int          bytes_seen, stops, miscompares = 0, checked = 0, cyc = 0;
  logic [31:0] seed = 32'h9399;
  wire         sda_w = ~(sda_oe | pull);
  wire         scl_w = ~scl_oe;
  two_wire_unit #(.QUARTER(4)) two_wire_unit_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
  two_wire_slave_model two_wire_slave_model_i (.clk(clk), .scl(scl_w), .sda(sda_w), .sda_pull(pull),
    .ack_en(ack_en), .grab(grab), .last_byte(last_byte), .bytes_seen(bytes_seen), .stops(stops));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    // Values seen here are those standing at this rising edge
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input logic ld, input logic [7:0] d, input logic [7:0] ctl, input logic [7:0] exp);
    logic [31:0] q;
    int          n;
    n = 0;
    if (ld) bus(1'b1, OFS_DATA, d, q);
    bus(1'b1, OFS_CONTROL, ctl, q);
    `CHK(irq, 1'b0)
    q = 32'h0000_0000;
    while (q[B_FLAG] !== 1'b1 && n < 300) begin
      bus(1'b0, OFS_CONTROL, 8'h00, q);
      n++;
    end
    `CHK(q[B_FLAG], 1'b1)
    `CHK(irq, ctl[B_IE])
    bus(1'b0, OFS_STATUS, 8'h00, q);
    `CHK(q[7:0] & STATUS_MASK, exp)
    if (ld && exp != ST_ARB_LOST) `CHK(last_byte, d)
  endtask
  task automatic stop_seen(input int n);
    int k;
    k = 0;
    while (stops == n && k < 500) begin
      @(posedge clk);
      k++;
    end
    `CHK(stops, n + 1)
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0]  b;
    int          n;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    ack_en = 1'b1;
    grab = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_CONTROL, 8'h00, q);
    `CHK(q[7:0], CONTROL_RESET)
    bus(1'b0, OFS_STATUS, 8'h00, q);
    `CHK(q[7:0], STATUS_RESET)
    bus(1'b0, 5'h14, 8'h00, q);
    `CHK(q, 32'h0000_0000)
    // Data write while idle must bounce and raise the collision event
    bus(1'b1, OFS_IRQ_MSK, 8'h02, q);
    bus(1'b1, OFS_DATA, rnd(), q);
    bus(1'b0, OFS_CONTROL, 8'h00, q);
    `CHK(q[B_WCOL], 1'b1)
    bus(1'b0, OFS_DATA, 8'h00, q);
    `CHK(q[7:0], DATA_RESET)
    `CHK(irq, 1'b1)
    bus(1'b1, OFS_IRQ_ST, 8'h02, q);
    bus(1'b1, OFS_CONTROL, 8'h08, q);
    `CHK(irq, 1'b0)
    step(1'b0, 8'h00, 8'hA5, ST_START);
    n = bytes_seen;
    repeat (60) @(posedge clk);
    `CHK(bytes_seen, n)
    step(1'b1, {rnd() & 8'h7E}, 8'h85, ST_ADDR_ACK);
    for (int i = 0; i < 4; i++) begin
      ack_en <= i[0];
      step(1'b1, rnd(), 8'h84, i[0] ? ST_DATA_ACK : ST_DATA_NAK);
    end
    n = stops;
    step(1'b0, 8'h00, 8'hA4, ST_RSTART);
    `CHK(stops, n)
    ack_en <= 1'b0;
    step(1'b1, rnd() | 8'h01, 8'h84, ST_RX_ADDR_NAK);
    bus(1'b0, OFS_STATUS, 8'h00, q);
    `CHK(q[9:8], 2'b01)
    step(1'b0, 8'h00, 8'hB4, ST_START);
    `CHK(stops, n + 1)
    bus(1'b0, OFS_CONTROL, 8'h00, q);
    `CHK(q[B_STOP], 1'b0)
    step(1'b1, rnd() & 8'hFE, 8'h84, ST_ADDR_NAK);
    step(1'b0, 8'h00, 8'hA4, ST_RSTART);
    grab <= 1'b1;
    step(1'b1, rnd() | 8'h80, 8'h84, ST_ARB_LOST);
    grab <= 1'b0;
    ack_en <= 1'b1;
    bus(1'b1, OFS_CONTROL, 8'h84, q);
    repeat (40) @(posedge clk);
    bus(1'b0, OFS_STATUS, 8'h00, q);
    `CHK(q[9:8], 2'b11)
    `CHK(sda_oe | scl_oe, 1'b0)
    step(1'b0, 8'h00, 8'hA4, ST_START);
    step(1'b1, rnd() & 8'hFE, 8'h84, ST_ADDR_ACK);
    n = stops;
    bus(1'b1, OFS_CONTROL, 8'h94, q);
    stop_seen(n);
    n = 0;
    do begin
      bus(1'b0, OFS_CONTROL, 8'h00, q);
      n++;
    end while (q[B_STOP] !== 1'b0 && n < 20);
    `CHK(q[B_STOP], 1'b0)
    print_verdict();
  end
endmodule

// file: tb/two_wire_slave_model.sv
// Purpose: Slave receiver on the two-wire bus
// Assumes: Wire levels resolved by the bench; pull-ups on both lines
// Notes:   grab holds sda low to force a lost arbitration
`timescale 1ns/1ns
module two_wire_slave_model (
  // Sampling clock
  input  wire logic       clk,
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Control and observation
  input  wire logic       ack_en,
  input  wire logic       grab,
  output logic      [7:0] last_byte,
  output int              bytes_seen,
  output int              stops
);
  logic       scl_d = 1'b1;
  logic       sda_d = 1'b1;
  logic       ack_pull = 1'b0;
  logic [7:0] sh = 8'h00;
  int         cnt = 0;
  initial begin
    last_byte = 8'h00;
    bytes_seen = 0;
    stops = 0;
  end
  assign sda_pull = ack_pull | grab;
  always @(posedge clk) begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && scl_d && sda_d && !sda) begin
      cnt <= 0;
    end else if (scl && scl_d && !sda_d && sda) begin
      stops <= stops + 1;
    end else if (scl && !scl_d) begin
      if (cnt < 8) sh <= {sh[6:0], sda};
      cnt <= cnt + 1;
    end else if (!scl && scl_d) begin
      // Low on the ninth bit acknowledges, released high refuses
      if (cnt == 8) ack_pull <= ack_en;
      if (cnt == 9) begin
        ack_pull <= 1'b0;
        last_byte <= sh;
        bytes_seen <= bytes_seen + 1;
        cnt <= 0;
      end
    end
  end
endmodule
